// ==== hw/gmr_pkg.sv ====
// Package of register addresses, codes, keys and timing constants for the gateway register map
package gmr_pkg;
  // Register addresses (16-bit Modbus register numbers)
  localparam logic [15:0] ADDR_NAME_FIRST = 16'h1000;
  localparam logic [15:0] ADDR_NAME_LAST = 16'h100B;
  localparam logic [15:0] ADDR_STATUS = 16'h100C;
  localparam logic [15:0] ADDR_ACTIVE_TO = 16'h1020;
  localparam logic [15:0] ADDR_DEFINED_TO = 16'h1120;
  localparam logic [15:0] ADDR_RETRIGGER = 16'h1121;
  localparam logic [15:0] ADDR_RESTORE_A = 16'h113C;
  localparam logic [15:0] ADDR_RESTORE_B = 16'h113D;
  localparam logic [15:0] ADDR_SAVE_A = 16'h113E;
  localparam logic [15:0] ADDR_SAVE_B = 16'h113F;
  localparam logic [15:0] ADDR_IN_FIRST = 16'h0000;
  localparam logic [15:0] ADDR_IN_LAST = 16'h03FF;

  // Sequence keys
  localparam logic [15:0] KEY_RESTORE_A = 16'h6C6F;
  localparam logic [15:0] KEY_RESTORE_B = 16'h6164;
  localparam logic [15:0] KEY_SAVE_A = 16'h7361;
  localparam logic [15:0] KEY_SAVE_B = 16'h7665;

  // Defaults and timing
  localparam logic [15:0] DEFINED_TO_RESET = 16'h0BB8;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam longint CLK_HZ = 200_000_000;
  localparam longint MS_PER_S = 1000;
  localparam longint CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam longint KEY_WINDOW_S = 30;
  localparam longint KEY_WINDOW_MS = KEY_WINDOW_S * MS_PER_S;

  // Gateway status codes
  localparam logic [15:0] ST_OK = 16'h0000;
  localparam logic [15:0] ST_COMM_LOSS = 16'h0001;
  localparam logic [15:0] ST_NO_PLANNED = 16'h0002;
  localparam logic [15:0] ST_NO_TARGET = 16'h0004;
  localparam logic [15:0] ST_RENEW = 16'h0040;
  localparam logic [15:0] ST_INIT = 16'h007F;
  localparam logic [15:0] ST_WIRING = 16'h0080;
  localparam logic [15:0] ST_ACT_MISMATCH = 16'h0081;
  localparam logic [15:0] ST_PLAN_MISMATCH = 16'h0082;

  // Device name: 24 characters over 12 registers, arbitrary neutral text
  localparam int NAME_REGS = 12;
  localparam logic [191:0] NAME_TEXT = "GATEWAY-MODBUS-TCP-UNIT ";

  // Packer item kinds
  typedef enum logic {
    GMR_ITEM_BYTE,
    GMR_ITEM_WORD
  } gmr_item_t;
endpackage

// ==== hw/gmr_packer.sv ====
// Byte and word stream packer into 16-bit registers with padding
module gmr_packer
  import gmr_pkg::*;
#(
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic itemValid,
  input wire gmr_item_t itemKind,
  input wire logic [15:0] itemData,
  input wire logic moduleEnd,
  input wire logic frameStart,
  input wire logic [AW-1:0] rdIndex,
  output logic [15:0] rdData
);
  logic [15:0] mem [DEPTH];
  logic [AW-1:0] wrIdx_reg;
  logic halfFull_reg;
  logic [7:0] upper_reg;

  // Pack items: byte goes high first, then low; word or module end pads
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrIdx_reg <= '0;
      halfFull_reg <= 1'b0;
      upper_reg <= 8'h00;
    end else if (frameStart) begin
      wrIdx_reg <= '0;
      halfFull_reg <= 1'b0;
    end else if (itemValid && itemKind == GMR_ITEM_WORD) begin
      if (halfFull_reg) begin
        mem[wrIdx_reg] <= {upper_reg, 8'h00};
        mem[wrIdx_reg + AW'(1)] <= itemData;
        wrIdx_reg <= wrIdx_reg + AW'(2);
      end else begin
        mem[wrIdx_reg] <= itemData;
        wrIdx_reg <= wrIdx_reg + AW'(1);
      end
      halfFull_reg <= 1'b0;
    end else if (itemValid) begin
      if (halfFull_reg) begin
        mem[wrIdx_reg] <= {upper_reg, itemData[7:0]};
        wrIdx_reg <= wrIdx_reg + AW'(1);
        halfFull_reg <= moduleEnd ? 1'b0 : 1'b0;
      end else if (moduleEnd) begin
        mem[wrIdx_reg] <= {itemData[7:0], 8'h00};
        wrIdx_reg <= wrIdx_reg + AW'(1);
      end else begin
        upper_reg <= itemData[7:0];
        halfFull_reg <= 1'b1;
      end
    end else if (moduleEnd && halfFull_reg) begin
      mem[wrIdx_reg] <= {upper_reg, 8'h00};
      wrIdx_reg <= wrIdx_reg + AW'(1);
      halfFull_reg <= 1'b0;
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk) begin
    rdData <= mem[rdIndex];
  end

  a_word_whole: assert property (@(posedge sys_clk) disable iff (!resetn)
    itemValid && itemKind == GMR_ITEM_WORD && !frameStart |=> !halfFull_reg)
    else $error("word left packer half full");
  a_pad_advance: assert property (@(posedge sys_clk) disable iff (!resetn)
    itemValid && itemKind == GMR_ITEM_WORD && halfFull_reg && !frameStart
    |=> wrIdx_reg == $past(wrIdx_reg) + AW'(2))
    else $error("padding byte not inserted");
  a_module_end: assert property (@(posedge sys_clk) disable iff (!resetn)
    moduleEnd && !frameStart |=> !halfFull_reg)
    else $error("module end left half register");
  c_pad: cover property (@(posedge sys_clk) disable iff (!resetn)
    itemValid && itemKind == GMR_ITEM_WORD && halfFull_reg);
endmodule

// ==== hw/gmr_register_map.sv ====
// Gateway register map: status, name, packed inputs, watchdog and key sequences
// Notes on behaviour
// - Odd bytes before word get padding byte.
// - First byte high, second byte low.
// - Odd input module area padded to register.
// - Read-only name string ends at 0x100B.
// - Status codes zero, one, two.
// - Status codes for target missing, renew, init.
// - Status codes for wiring test, actual mismatch.
// - Status code for planned mismatch.
// - Timeout elapse switches all outputs off.
// - Defined timeout defaults to 3000 ms.
// - Zero timeout disables the shut-off.
// - Running watchdog readable in active register.
// - Any frame restarts the watchdog.
// - Write to retrigger register restarts watchdog.
// - Restore keys, second within thirty seconds.
// - Both keys in one multi-write accepted.
// - Restore takes effect, not stored.
// - Save commits only after second key.
module gmr_register_map
  import gmr_pkg::*;
#(
  parameter int AW = 10,
  parameter longint CYC_MS = CYC_PER_MS,
  parameter int KEY_MS = int'(KEY_WINDOW_MS)
) (
  input wire logic sys_clk,
  input wire logic resetn,
  // Register access from the Modbus-TCP frame engine
  input wire logic frameSeen,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic regRdValid,
  // Module bus condition pins
  input wire logic busCommFail,
  input wire logic noPlannedCfg,
  input wire logic noTargetCfg,
  input wire logic renewTarget,
  input wire logic busInit,
  input wire logic wiringTest,
  input wire logic actMismatch,
  input wire logic planMismatch,
  // Input data stream from the module bus
  input wire logic itemValid,
  input wire gmr_item_t itemKind,
  input wire logic [15:0] itemData,
  input wire logic moduleEnd,
  input wire logic cycleStart,
  // Non-volatile store and output control
  input wire logic [15:0] storedTimeout,
  input wire logic storedValid,
  output logic nvWrite,
  output logic [15:0] nvData,
  output logic commLossSafeState
);
  typedef enum logic [1:0] {
    GMR_KEY_IDLE,
    GMR_KEY_RESTORE,
    GMR_KEY_SAVE
  } gmr_key_t;

  // Write strobe decode for one register address
  function automatic logic wr_hit(input logic we, input logic [15:0] addr,
      input logic [15:0] target);
    return we && addr == target;
  endfunction

  logic [7:0] condA_reg;
  logic [7:0] condB_reg;
  logic [15:0] status_reg;
  logic [15:0] definedTo_reg;
  logic [15:0] activeTo_reg;
  logic [$clog2(CYC_MS+1)-1:0] msDiv_reg;
  logic msTick;
  logic safe_reg;
  gmr_key_t keyState_reg;
  logic [15:0] keyMs_reg;
  logic loadStrap_reg;
  logic [15:0] packData;
  logic inRange;
  logic nameRange;
  logic [3:0] nameIdx;
  logic restoreDone;
  logic saveDone;
  logic keyAbort;
  logic retrigHit;
  logic definedWr;

  // Two-stage synchroniser for the condition pins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      condA_reg <= 8'h00;
      condB_reg <= 8'h00;
    end else begin
      condA_reg <= {planMismatch, actMismatch, wiringTest, busInit,
                    renewTarget, noTargetCfg, noPlannedCfg, busCommFail};
      condB_reg <= condA_reg;
    end
  end

  // Status code by priority, no fault reads zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= ST_OK;
    end else if (condB_reg[0]) begin
      status_reg <= ST_COMM_LOSS;
    end else if (condB_reg[1]) begin
      status_reg <= ST_NO_PLANNED;
    end else if (condB_reg[2]) begin
      status_reg <= ST_NO_TARGET;
    end else if (condB_reg[3]) begin
      status_reg <= ST_RENEW;
    end else if (condB_reg[4]) begin
      status_reg <= ST_INIT;
    end else if (condB_reg[5]) begin
      status_reg <= ST_WIRING;
    end else if (condB_reg[6]) begin
      status_reg <= ST_ACT_MISMATCH;
    end else if (condB_reg[7]) begin
      status_reg <= ST_PLAN_MISMATCH;
    end else begin
      status_reg <= ST_OK;
    end
  end

  // Write strobes shared by the watchdog, the timeout register and the checks
  assign retrigHit = wr_hit(regWrite, regAddr, ADDR_RETRIGGER);
  assign definedWr = wr_hit(regWrite, regAddr, ADDR_DEFINED_TO);

  // Key sequence decode, both keys may arrive back to back in one multi-write
  assign keyAbort = regWrite && keyState_reg != GMR_KEY_IDLE &&
    ((keyState_reg == GMR_KEY_RESTORE && regAddr == ADDR_RESTORE_B &&
      regWrData != KEY_RESTORE_B) ||
     (keyState_reg == GMR_KEY_SAVE && regAddr == ADDR_SAVE_B &&
      regWrData != KEY_SAVE_B));
  assign restoreDone = regWrite && keyState_reg == GMR_KEY_RESTORE &&
    regAddr == ADDR_RESTORE_B && regWrData == KEY_RESTORE_B;
  assign saveDone = regWrite && keyState_reg == GMR_KEY_SAVE &&
    regAddr == ADDR_SAVE_B && regWrData == KEY_SAVE_B;

  // Key sequence state with thirty second window
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      keyState_reg <= GMR_KEY_IDLE;
      keyMs_reg <= ZERO_WORD;
    end else if (regWrite && regAddr == ADDR_RESTORE_A && regWrData == KEY_RESTORE_A) begin
      keyState_reg <= GMR_KEY_RESTORE;
      keyMs_reg <= ZERO_WORD;
    end else if (regWrite && regAddr == ADDR_SAVE_A && regWrData == KEY_SAVE_A) begin
      keyState_reg <= GMR_KEY_SAVE;
      keyMs_reg <= ZERO_WORD;
    end else if (restoreDone || saveDone || keyAbort) begin
      keyState_reg <= GMR_KEY_IDLE;
    end else if (keyState_reg != GMR_KEY_IDLE && msTick) begin
      if (keyMs_reg >= 16'(KEY_MS)) begin
        keyState_reg <= GMR_KEY_IDLE;
      end else begin
        keyMs_reg <= keyMs_reg + 16'h0001;
      end
    end
  end

  // Defined timeout register, loaded from store once after reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      definedTo_reg <= DEFINED_TO_RESET;
      loadStrap_reg <= 1'b0;
    end else if (!loadStrap_reg) begin
      loadStrap_reg <= 1'b1;
      if (storedValid) begin
        definedTo_reg <= storedTimeout;
      end
    end else if (restoreDone) begin
      definedTo_reg <= DEFINED_TO_RESET;
    end else if (definedWr) begin
      definedTo_reg <= regWrData;
    end
  end

  // Commit to non-volatile store only on the second save key
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      nvWrite <= 1'b0;
      nvData <= ZERO_WORD;
    end else begin
      nvWrite <= saveDone;
      if (saveDone) begin
        nvData <= definedTo_reg;
      end
    end
  end

  // Millisecond prescaler
  assign msTick = msDiv_reg == ($bits(msDiv_reg))'(CYC_MS - 1);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      msDiv_reg <= '0;
    end else if (msTick) begin
      msDiv_reg <= '0;
    end else begin
      msDiv_reg <= msDiv_reg + 1'b1;
    end
  end

  // Watchdog: reload on any frame or retrigger write, count down in ms
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      activeTo_reg <= DEFINED_TO_RESET;
    end else if (frameSeen || retrigHit) begin
      activeTo_reg <= definedTo_reg;
    end else if (definedWr) begin
      activeTo_reg <= regWrData;
    end else if (msTick && activeTo_reg != ZERO_WORD) begin
      activeTo_reg <= activeTo_reg - 16'h0001;
    end
  end

  // Outputs off when the running watchdog hits zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      safe_reg <= 1'b0;
    end else if (definedTo_reg == ZERO_WORD) begin
      safe_reg <= 1'b0;
    end else if (frameSeen || retrigHit) begin
      safe_reg <= 1'b0;
    end else if (activeTo_reg == ZERO_WORD) begin
      safe_reg <= 1'b1;
    end
  end
  assign commLossSafeState = safe_reg;

  // Input data packed into registers
  gmr_packer #(
    .DEPTH(1 << AW),
    .AW(AW)
  ) u_packer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .itemValid(itemValid),
    .itemKind(itemKind),
    .itemData(itemData),
    .moduleEnd(moduleEnd),
    .frameStart(cycleStart),
    .rdIndex(regAddr[AW-1:0]),
    .rdData(packData)
  );

  // Read decode, one cycle latency; unmapped reads return zero
  assign inRange = regAddr <= ADDR_IN_LAST;
  assign nameRange = regAddr >= ADDR_NAME_FIRST && regAddr <= ADDR_NAME_LAST;
  assign nameIdx = 4'(regAddr - ADDR_NAME_FIRST);
  logic rdIn_reg;
  logic [15:0] rdHold_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdIn_reg <= 1'b0;
      rdHold_reg <= ZERO_WORD;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      rdIn_reg <= inRange;
      if (nameRange) begin
        rdHold_reg <= NAME_TEXT[191 - 16*nameIdx -: 16];
      end else if (regAddr == ADDR_STATUS) begin
        rdHold_reg <= status_reg;
      end else if (regAddr == ADDR_ACTIVE_TO) begin
        rdHold_reg <= activeTo_reg;
      end else if (regAddr == ADDR_DEFINED_TO) begin
        rdHold_reg <= definedTo_reg;
      end else begin
        rdHold_reg <= ZERO_WORD;
      end
    end
  end
  assign regRdData = rdIn_reg ? packData : rdHold_reg;

  // Watchdog and key sequence checks
  a_reset_default: assert property (@(posedge sys_clk) disable iff (!resetn)
    restoreDone |=> definedTo_reg == DEFINED_TO_RESET)
    else $error("restore did not load default");
  a_restore_volatile: assert property (@(posedge sys_clk) disable iff (!resetn)
    restoreDone |=> !nvWrite)
    else $error("restore wrote the store");
  a_zero_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    definedTo_reg == ZERO_WORD |=> !safe_reg)
    else $error("shut-off active with zero timeout");
  a_retrigger: assert property (@(posedge sys_clk) disable iff (!resetn)
    retrigHit |=> activeTo_reg == $past(definedTo_reg))
    else $error("retrigger did not reload");
  a_frame_reload: assert property (@(posedge sys_clk) disable iff (!resetn)
    frameSeen |=> activeTo_reg == $past(definedTo_reg) && !safe_reg)
    else $error("frame did not reload watchdog");
  a_expire_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    activeTo_reg == ZERO_WORD && definedTo_reg != ZERO_WORD && !frameSeen && !regWrite
    |=> safe_reg)
    else $error("outputs not switched off at expiry");
  a_save_commit: assert property (@(posedge sys_clk) disable iff (!resetn)
    nvWrite |-> $past(saveDone))
    else $error("store written without save key");
  a_key_abort: assert property (@(posedge sys_clk) disable iff (!resetn)
    keyAbort |=> keyState_reg == GMR_KEY_IDLE && !nvWrite)
    else $error("wrong key did not abandon");
  a_key_window: assert property (@(posedge sys_clk) disable iff (!resetn)
    keyState_reg != GMR_KEY_IDLE && msTick && keyMs_reg >= 16'(KEY_MS) && !regWrite
    |=> keyState_reg == GMR_KEY_IDLE)
    else $error("late key sequence not abandoned");
  a_ms_count: assert property (@(posedge sys_clk) disable iff (!resetn)
    msTick && activeTo_reg != ZERO_WORD && !frameSeen && !regWrite
    |=> activeTo_reg == $past(activeTo_reg) - 16'h0001)
    else $error("watchdog step wrong");
  a_active_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    regRead && regAddr == ADDR_ACTIVE_TO |=> regRdValid && regRdData == $past(activeTo_reg))
    else $error("active timeout read wrong");

  // Status code checks
  a_status_ok: assert property (@(posedge sys_clk) disable iff (!resetn)
    condB_reg == 8'h00 |=> status_reg == ST_OK)
    else $error("status not zero without fault");
  a_comm_code: assert property (@(posedge sys_clk) disable iff (!resetn)
    condB_reg[0] |=> status_reg == ST_COMM_LOSS)
    else $error("comm loss code missing");
  a_init_code: assert property (@(posedge sys_clk) disable iff (!resetn)
    condB_reg[4:0] == 5'h10 |=> status_reg == ST_INIT)
    else $error("init code missing");
  a_wiring_code: assert property (@(posedge sys_clk) disable iff (!resetn)
    condB_reg[5:0] == 6'h20 |=> status_reg == ST_WIRING)
    else $error("wiring test code missing");
  a_plan_code: assert property (@(posedge sys_clk) disable iff (!resetn)
    condB_reg == 8'h80 |=> status_reg == ST_PLAN_MISMATCH)
    else $error("planned mismatch code missing");
  a_status_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    regRead && regAddr == ADDR_STATUS |=> regRdValid && regRdData == $past(status_reg))
    else $error("status read wrong");
  c_restore: cover property (@(posedge sys_clk) disable iff (!resetn) restoreDone);
  c_save: cover property (@(posedge sys_clk) disable iff (!resetn) saveDone);
  c_expire: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(safe_reg));
  c_late_key: cover property (@(posedge sys_clk) disable iff (!resetn)
    keyState_reg != GMR_KEY_IDLE && msTick && keyMs_reg >= 16'(KEY_MS));
endmodule

// ==== tb/gmr_host_model.sv ====
// Modbus-TCP master model: register requests and frame pulses towards the gateway
module gmr_host_model (
  input wire logic sys_clk,
  output logic frameSeen,
  output logic regWrite,
  output logic regRead,
  output logic [15:0] regAddr,
  output logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic regRdValid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels at time zero
  initial begin
    frameSeen = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 16'h0000;
    regWrData = 16'h0000;
  end

  // One frame exchanged with the gateway, one cycle wide
  task automatic frame();
    @(posedge sys_clk);
    frameSeen <= 1'b1;
    @(posedge sys_clk);
    frameSeen <= 1'b0;
  endtask

  // Single register write; released lines show the inverse of the last value
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask

  // Two registers of one multi-register write, on consecutive cycles
  task automatic wr_pair(input logic [15:0] a, input logic [15:0] d0, input logic [15:0] d1);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d0;
    @(posedge sys_clk);
    regAddr <= a + 16'h0001;
    regWrData <= d1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d1;
  endtask

  // Register read, answer taken at the edge that sees the valid pulse
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    int n;
    v = 16'hxxxx;
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    for (n = 0; n < 8; n++) begin
      @(posedge sys_clk);
      if (regRdValid === 1'b1) begin
        v = regRdData;
        break;
      end
    end
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the gateway register map
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gmr_pkg::*;

  logic sys_clk, resetn, frameSeen, regWrite, regRead, regRdValid;
  logic [15:0] regAddr, regWrData, regRdData, nvData, v, nvSeen;
  logic [7:0] cond;
  logic itemValid, moduleEnd, cycleStart, nvWrite, commLossSafeState;
  gmr_item_t itemKind;
  logic [15:0] itemData;
  int bad_count = 0, cmp_count = 0, nvCount = 0, cycles = 0, i;
  logic [15:0] codes [8] = '{ST_COMM_LOSS, ST_NO_PLANNED, ST_NO_TARGET, ST_RENEW,
                             ST_INIT, ST_WIRING, ST_ACT_MISMATCH, ST_PLAN_MISMATCH};

  gmr_host_model host_u (.sys_clk(sys_clk), .frameSeen(frameSeen), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid));

  gmr_register_map #(.AW(10), .CYC_MS(4), .KEY_MS(5)) dut_u (.sys_clk(sys_clk),
    .resetn(resetn), .frameSeen(frameSeen), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .busCommFail(cond[0]), .noPlannedCfg(cond[1]),
    .noTargetCfg(cond[2]), .renewTarget(cond[3]), .busInit(cond[4]),
    .wiringTest(cond[5]), .actMismatch(cond[6]), .planMismatch(cond[7]),
    .itemValid(itemValid), .itemKind(itemKind), .itemData(itemData),
    .moduleEnd(moduleEnd), .cycleStart(cycleStart), .storedTimeout(16'h0000),
    .storedValid(1'b0), .nvWrite(nvWrite), .nvData(nvData),
    .commLossSafeState(commLossSafeState));

  // Clock of 5 ns
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Commit monitor and hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (nvWrite === 1'b1) begin
      nvCount++;
      nvSeen = nvData;
    end
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_reg(input logic [15:0] a, input logic [15:0] exp);
    host_u.rd(a, v);
    chk($sformatf("reg %h", a), exp, v);
  endtask

  task automatic chk_safe(input logic exp);
    chk("safe state", {15'h0000, exp}, {15'h0000, commLossSafeState});
  endtask

  // One packer item, bytes carried in the low half
  task automatic put(input gmr_item_t k, input logic [15:0] d, input logic last);
    @(posedge sys_clk);
    itemValid <= 1'b1;
    itemKind <= k;
    itemData <= d;
    moduleEnd <= last;
    @(posedge sys_clk);
    itemValid <= 1'b0;
    moduleEnd <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    cond = 8'h00;
    itemValid = 1'b0;
    itemKind = GMR_ITEM_BYTE;
    itemData = 16'h0000;
    moduleEnd = 1'b0;
    cycleStart = 1'b0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    // Reset values, name string, unmapped and read-only places
    chk_reg(ADDR_DEFINED_TO, 16'h0BB8);
    chk_reg(ADDR_STATUS, ST_OK);
    chk_reg(ADDR_NAME_FIRST, NAME_TEXT[191:176]);
    chk_reg(ADDR_NAME_LAST, NAME_TEXT[15:0]);
    host_u.wr(ADDR_NAME_LAST, 16'h5A5A);
    chk_reg(ADDR_NAME_LAST, NAME_TEXT[15:0]);
    chk_reg(16'h2000, 16'h0000);
    $display("Test reset values done");
    // Every status condition alone
    for (i = 0; i < 8; i++) begin
      cond <= 8'h01 << i;
      repeat (6) @(posedge sys_clk);
      chk_reg(ADDR_STATUS, codes[i]);
    end
    cond <= 8'h00;
    host_u.wr(ADDR_STATUS, 16'h0081);
    repeat (6) @(posedge sys_clk);
    chk_reg(ADDR_STATUS, ST_OK);
    $display("Test status codes done");
    // Watchdog of 10 ms at 4 cycles per ms
    host_u.frame();
    host_u.wr(ADDR_DEFINED_TO, 16'h000A);
    host_u.rd(ADDR_ACTIVE_TO, v);
    cmp_count++;
    if (v !== 16'h000A && v !== 16'h0009) begin
      bad_count++;
      $display("BAD active timeout expected 000a or 0009 seen %h", v);
    end
    repeat (22) @(posedge sys_clk);
    chk_safe(1'b0);
    host_u.wr(ADDR_RETRIGGER, 16'h0001);
    repeat (30) @(posedge sys_clk);
    chk_safe(1'b0);
    repeat (30) @(posedge sys_clk);
    chk_safe(1'b1);
    host_u.frame();
    repeat (3) @(posedge sys_clk);
    chk_safe(1'b0);
    host_u.wr(ADDR_DEFINED_TO, ZERO_WORD);
    repeat (100) @(posedge sys_clk);
    chk_safe(1'b0);
    $display("Test watchdog done");
    // Restore: good pair, wrong key, late key
    host_u.wr(ADDR_DEFINED_TO, 16'h000A);
    host_u.wr_pair(ADDR_RESTORE_A, KEY_RESTORE_A, KEY_RESTORE_B);
    chk_reg(ADDR_DEFINED_TO, DEFINED_TO_RESET);
    chk("commit count", 16'h0000, 16'(nvCount));
    host_u.wr(ADDR_DEFINED_TO, 16'h000A);
    host_u.wr(ADDR_RESTORE_A, KEY_RESTORE_A);
    host_u.wr(ADDR_RESTORE_B, KEY_SAVE_B);
    host_u.wr(ADDR_RESTORE_B, KEY_RESTORE_B);
    chk_reg(ADDR_DEFINED_TO, 16'h000A);
    host_u.wr(ADDR_RESTORE_A, KEY_RESTORE_A);
    repeat (40) @(posedge sys_clk);
    host_u.wr(ADDR_RESTORE_B, KEY_RESTORE_B);
    chk_reg(ADDR_DEFINED_TO, 16'h000A);
    $display("Test restore done");
    // Save: nothing before the second key, late key refused
    host_u.wr(ADDR_DEFINED_TO, 16'h1234);
    host_u.wr(ADDR_SAVE_A, KEY_SAVE_A);
    repeat (3) @(posedge sys_clk);
    chk("commit count", 16'h0000, 16'(nvCount));
    host_u.wr(ADDR_SAVE_B, KEY_SAVE_B);
    repeat (3) @(posedge sys_clk);
    chk("commit count", 16'h0001, 16'(nvCount));
    chk("commit data", 16'h1234, nvSeen);
    host_u.wr(ADDR_SAVE_A, KEY_SAVE_A);
    repeat (40) @(posedge sys_clk);
    host_u.wr(ADDR_SAVE_B, KEY_SAVE_B);
    repeat (3) @(posedge sys_clk);
    chk("commit count", 16'h0001, 16'(nvCount));
    $display("Test save done");
    // Packing: three bytes then a word, then an odd module end
    @(posedge sys_clk);
    cycleStart <= 1'b1;
    @(posedge sys_clk);
    cycleStart <= 1'b0;
    put(GMR_ITEM_BYTE, 16'h0011, 1'b0);
    put(GMR_ITEM_BYTE, 16'h0022, 1'b0);
    put(GMR_ITEM_BYTE, 16'h0033, 1'b0);
    put(GMR_ITEM_WORD, 16'hABCD, 1'b0);
    put(GMR_ITEM_BYTE, 16'h0044, 1'b1);
    put(GMR_ITEM_BYTE, 16'h0055, 1'b0);
    put(GMR_ITEM_BYTE, 16'h0066, 1'b0);
    put(GMR_ITEM_BYTE, 16'h0077, 1'b0);
    // Module end alone closes a half-filled register
    @(posedge sys_clk);
    moduleEnd <= 1'b1;
    @(posedge sys_clk);
    moduleEnd <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_reg(16'h0000, 16'h1122);
    chk_reg(16'h0001, 16'h3300);
    chk_reg(16'h0002, 16'hABCD);
    chk_reg(16'h0003, 16'h4400);
    chk_reg(16'h0004, 16'h5566);
    chk_reg(16'h0005, 16'h7700);
    $display("Test packing done");
    give_verdict();
  end
endmodule
